/* File: logic/scx_call_unit.sv */
// Subroutine-call decode and execution with its program counter.
// Assumes the fetch side presents insn for a whole instruction cycle from Q1,
// and the stack accepts one push strobe per call.
// Notes on behaviour
// - Call is recognised when top three word bits are 100; low eleven are literal.
// - Call first pushes current address plus one onto the return stack.
// - Literal, any value 0 to 2047, loads program counter bits 10 to 0.
// - Latch bits 4 and 3 load program counter bits 12 and 11.
// - Call takes two instruction cycles, one word; second cycle is idle.
// - Q1 decode, Q2 literal and push, Q3 process, Q4 write PC; cycle two idle.
`timescale 1ns/1ps
`default_nettype none
module scx_call_unit (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Instruction and latch
	input wire logic [scx_pkg::INSN_W-1:0] insn,
	input wire logic insn_valid,
	input wire logic [scx_pkg::LATCH_W-1:0] pc_high_latch,
	// Stack push
	output logic stack_push,
	output logic [scx_pkg::PC_W-1:0] stack_top,
	// Program counter and status
	output logic [scx_pkg::PC_W-1:0] pc,
	output logic [scx_pkg::PC_W-1:0] pc_next,
	output logic busy,
	output logic phase_q1,
	output logic status_we
);
	typedef enum logic [1:0] {SCX_IDLE, SCX_EXEC, SCX_NOP} scx_state_t;

	// Quarter phases per instruction cycle, and enabled edges spent on one call
	localparam int unsigned QUARTERS = 2 ** $bits(scx_pkg::scx_phase_t);
	localparam int unsigned BUSY_EDGES = scx_pkg::CALL_CYCLES * QUARTERS;
	localparam int unsigned PAGE_W = scx_pkg::LATCH_PAGE_HI - scx_pkg::LATCH_PAGE_LO + 1;
	localparam int unsigned OPC_W = scx_pkg::OPC_HI - scx_pkg::OPC_LO + 1;

	// Elaboration checks: the fields must tile the word and the program counter
	if (scx_pkg::LIT_W + PAGE_W != scx_pkg::PC_W) begin : g_chk_pc
		$error("page and literal widths must fill the program counter");
	end
	if (scx_pkg::OPC_LO != scx_pkg::LIT_W) begin : g_chk_opc_lo
		$error("opcode field must sit directly above the literal");
	end
	if (scx_pkg::OPC_HI != scx_pkg::INSN_W - 1) begin : g_chk_opc_hi
		$error("opcode field must end at the top of the word");
	end
	if (OPC_W != $bits(scx_pkg::OPC_CALL)) begin : g_chk_opc_w
		$error("opcode constant width does not match its field");
	end
	if (scx_pkg::LATCH_PAGE_HI >= scx_pkg::LATCH_W) begin : g_chk_latch
		$error("page bits lie outside the high latch");
	end
	if (scx_pkg::LATCH_PAGE_LO > scx_pkg::LATCH_PAGE_HI) begin : g_chk_page
		$error("page field bounds are reversed");
	end
	if (BUSY_EDGES < 2 || BUSY_EDGES > 15) begin : g_chk_busy
		$error("busy edge count does not fit its counter");
	end

	scx_if ph ();
	scx_state_t state_q;
	logic [scx_pkg::LIT_W-1:0] lit_q;
	logic [scx_pkg::PC_W-1:0] pc_q;
	logic [scx_pkg::PC_W-1:0] stack_top_q;
	logic push_q;
	logic is_call;
	logic at_q1;
	logic at_q2;
	logic at_q4;
	// Enabled edges spent inside the current call, for the length checks
	logic [3:0] busy_cnt_q;

	scx_phase u_phase (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.ph(ph.seq)
	);

	assign at_q1 = clk_en && (ph.phase == scx_pkg::SCX_Q1);
	assign at_q2 = clk_en && (ph.phase == scx_pkg::SCX_Q2);
	assign at_q4 = clk_en && (ph.phase == scx_pkg::SCX_Q4);
	assign is_call = insn_valid && (insn[scx_pkg::OPC_HI:scx_pkg::OPC_LO] == scx_pkg::OPC_CALL);

	// Sequencer over whole instruction cycles
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= SCX_IDLE;
		end else begin
			case (state_q)
				SCX_IDLE: if (at_q1 && is_call) state_q <= SCX_EXEC;
				SCX_EXEC: if (at_q4) state_q <= SCX_NOP;
				SCX_NOP: if (at_q4) state_q <= SCX_IDLE;
				default: state_q <= SCX_IDLE;
			endcase
		end
	end

	// Literal capture and push in Q2
	// The fetch side must hold insn through Q2: the literal is taken only there,
	// and a word shown in the idle second cycle is never looked at again.
	// The push is a single-edge strobe so the stack moves exactly once per call.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lit_q <= '0;
			stack_top_q <= scx_pkg::PC_RESET;
			push_q <= 1'b0;
		end else if (clk_en) begin
			push_q <= 1'b0;
			if (state_q == SCX_EXEC && at_q2) begin
				lit_q <= insn[scx_pkg::LIT_W-1:0];
				stack_top_q <= pc_q + scx_pkg::PC_ONE;
				push_q <= 1'b1;
			end
		end
	end

	// Target address: page from latch, offset from literal
	assign pc_next = {pc_high_latch[scx_pkg::LATCH_PAGE_HI:scx_pkg::LATCH_PAGE_LO], lit_q};

	// Program counter: Q4 of the first cycle writes target; other valid words step by one
	// The page comes from the latch as it stands at that Q4 edge; the latch itself is never written.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pc_q <= scx_pkg::PC_RESET;
		end else if (at_q4) begin
			case (state_q)
				SCX_EXEC: pc_q <= pc_next;
				SCX_NOP: pc_q <= pc_q;
				SCX_IDLE: if (insn_valid) pc_q <= pc_q + scx_pkg::PC_ONE;
				default: pc_q <= pc_q;
			endcase
		end
	end

	assign stack_push = push_q;
	assign stack_top = stack_top_q;
	assign pc = pc_q;
	assign busy = (state_q != SCX_IDLE);
	assign phase_q1 = (ph.phase == scx_pkg::SCX_Q1);
	assign status_we = 1'b0;

	// Length of a call in enabled edges; cleared whenever no call runs
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_cnt_q <= '0;
		end else if (clk_en) begin
			if (state_q == SCX_IDLE) begin
				busy_cnt_q <= '0;
			end else begin
				busy_cnt_q <= busy_cnt_q + 4'h1;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	call_start_a: assert property (at_q1 && is_call && state_q == SCX_IDLE |=> state_q == SCX_EXEC)
		else $error("call not decoded");
	push_value_a: assert property ($rose(push_q) |-> stack_top_q == $past(pc_q) + scx_pkg::PC_ONE)
		else $error("wrong return address");
	pc_low_a: assert property (at_q4 && state_q == SCX_EXEC |=> pc_q[scx_pkg::LIT_W-1:0] == lit_q)
		else $error("literal not in pc");
	pc_page_a: assert property (at_q4 && state_q == SCX_EXEC |=>
		pc_q[scx_pkg::PC_W-1:scx_pkg::LIT_W] == $past(pc_high_latch[scx_pkg::LATCH_PAGE_HI:scx_pkg::LATCH_PAGE_LO]))
		else $error("page bits wrong");
	nop_cycle_a: assert property (at_q4 && state_q == SCX_EXEC |=> state_q == SCX_NOP)
		else $error("second cycle missing");
	nop_hold_a: assert property (state_q == SCX_NOP |=> $stable(pc_q) && !push_q)
		else $error("activity in idle cycle");
	push_once_a: assert property (push_q |=> !push_q)
		else $error("double push");
	no_status_a: assert property (!status_we)
		else $error("status written");

	busy_len_a: assert property (busy && clk_en && busy_cnt_q == 4'(BUSY_EDGES - 2) |=> !busy)
		else $error("call length wrong");
	busy_max_a: assert property (busy_cnt_q < 4'(BUSY_EDGES))
		else $error("call overran");
	nop_refuse_a: assert property (state_q == SCX_NOP && at_q1 |=> state_q == SCX_NOP)
		else $error("word taken in idle cycle");

	push_exec_a: assert property (push_q |-> state_q == SCX_EXEC)
		else $error("push outside first cycle");
	idle_push_a: assert property (state_q == SCX_IDLE |-> !push_q)
		else $error("push without call");
	phase_wrap_a: assert property (clk_en && ph.phase == scx_pkg::SCX_Q4 |=> ph.phase == scx_pkg::SCX_Q1)
		else $error("phase did not wrap");
	phase_step_a: assert property (clk_en && ph.phase != scx_pkg::SCX_Q4 |=> ph.phase != scx_pkg::SCX_Q1)
		else $error("phase wrapped early");

	pc_step_a: assert property (at_q4 && state_q == SCX_IDLE && insn_valid |=>
		pc_q == $past(pc_q) + scx_pkg::PC_ONE)
		else $error("pc did not step");

	call_seen_c: cover property (state_q == SCX_EXEC);
	call_done_c: cover property (state_q == SCX_NOP ##1 state_q == SCX_IDLE);
	call_back_c: cover property (state_q == SCX_NOP && at_q4 ##2 state_q == SCX_EXEC);
	step_seen_c: cover property (at_q4 && state_q == SCX_IDLE && insn_valid);
	nop_call_c: cover property (state_q == SCX_NOP && at_q1 && is_call);
endmodule : scx_call_unit
`default_nettype wire

/* File: logic/scx_if.sv */
// Carrier for the phase sequencer signals between the call unit and its phase counter.
// Assumes one clock; the phase counter owns the phase.
`timescale 1ns/1ps
`default_nettype none
interface scx_if;
	scx_pkg::scx_phase_t phase;
	logic cycle_end;
	modport seq (output phase, output cycle_end);
	modport user (input phase, input cycle_end);
endinterface : scx_if
`default_nettype wire

/* File: logic/scx_phase.sv */
// Quarter-phase counter: Q1..Q4 advance once per enabled clock.
// Assumes clk is the core quarter clock and clk_en freezes it.
`timescale 1ns/1ps
`default_nettype none
module scx_phase (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Phase out
	scx_if.seq ph
);
	scx_pkg::scx_phase_t phase_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase_q <= scx_pkg::SCX_Q1;
		end else if (clk_en) begin
			case (phase_q)
				scx_pkg::SCX_Q1: phase_q <= scx_pkg::SCX_Q2;
				scx_pkg::SCX_Q2: phase_q <= scx_pkg::SCX_Q3;
				scx_pkg::SCX_Q3: phase_q <= scx_pkg::SCX_Q4;
				scx_pkg::SCX_Q4: phase_q <= scx_pkg::SCX_Q1;
				default: phase_q <= scx_pkg::SCX_Q1;
			endcase
		end
	end

	assign ph.phase = phase_q;
	assign ph.cycle_end = clk_en && (phase_q == scx_pkg::SCX_Q4);
endmodule : scx_phase
`default_nettype wire

/* File: logic/scx_pkg.sv */
// Constants and types for the subroutine-call execution block.
// Assumes a 14-bit instruction word and a 13-bit program counter.
package scx_pkg;
	localparam int unsigned INSN_W = 14;
	localparam int unsigned PC_W = 13;
	localparam int unsigned LIT_W = 11;
	localparam int unsigned LATCH_W = 8;
	localparam int unsigned OPC_HI = 13;
	localparam int unsigned OPC_LO = 11;
	localparam logic [2:0] OPC_CALL = 3'h4;
	localparam int unsigned LATCH_PAGE_HI = 4;
	localparam int unsigned LATCH_PAGE_LO = 3;
	localparam int unsigned CALL_CYCLES = 2;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
	typedef enum logic [1:0] {SCX_Q1, SCX_Q2, SCX_Q3, SCX_Q4} scx_phase_t;
endpackage : scx_pkg

/* File: verification/scx_call_unit_bench.sv */
// Self-checking bench for the subroutine-call unit: calls, non-call words and words refused while busy.
// Assumes take on the Q1 edge, push seen after the Q2 edge, pc written on the Q4 edge, 8 busy edges.
`timescale 1ns/1ps
`default_nettype none
module scx_call_unit_bench;
	logic clk;
	logic sys_rst;
	logic clk_en;
	logic [13:0] insn;
	logic insn_valid;
	logic [7:0] pc_high_latch;
	logic stack_push;
	logic busy;
	logic phase_q1;
	logic status_we;
	logic [12:0] stack_top;
	logic [12:0] pc;
	logic [12:0] pc_next;
	logic [12:0] exp_pc;
	int bad_count;
	int comparisons;
	int cycles;

	scx_call_unit u_scx_call_unit (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .insn(insn),
		.insn_valid(insn_valid), .pc_high_latch(pc_high_latch), .stack_push(stack_push), .stack_top(stack_top),
		.pc(pc), .pc_next(pc_next), .busy(busy), .phase_q1(phase_q1), .status_we(status_we));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			test_done();
		end
	end

	task chk(input string what, input logic [12:0] exp, input logic [12:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			bad_count++;
		end
	endtask : chk

	// Runs one instruction from its Q1 edge; a call also spans its idle second cycle
	task op(input logic [13:0] w, input logic v, input logic [7:0] lat);
		logic c;
		logic [12:0] tgt;
		int n;
		c = v && (w[13:11] === 3'b100);
		tgt = {lat[4:3], w[10:0]};
		n = c ? 8 : 4;
		insn <= w;
		insn_valid <= v;
		pc_high_latch <= lat;
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			if (i == 0) chk("phase_q1", 13'h1, {12'h0, phase_q1});
			chk("busy", {12'h0, c && i > 0}, {12'h0, busy});
			chk("stack_push", {12'h0, c && i == 2}, {12'h0, stack_push});
			chk("status_we", 13'h0, {12'h0, status_we});
			chk("pc", (c && i >= 4) ? tgt : exp_pc, pc);
			if (c && i == 2) chk("pc_next", tgt, pc_next);
			if (c && i == 2) chk("stack_top", exp_pc + 13'h1, stack_top);
			@(posedge clk);
			// Second cycle: a fresh call word and another page must both be ignored
			if (c && i == 3) begin
				insn <= {3'b100, ~w[10:0]};
				pc_high_latch <= ~lat;
			end
		end
		exp_pc = c ? tgt : exp_pc + {12'h0, v};
	endtask : op

	task test_calls;
		op({3'b100, 11'h000}, 1'b1, 8'h18);
		op({3'b100, 11'h7ff}, 1'b1, 8'he7);
		op({3'b100, 11'h2aa}, 1'b1, 8'h08);
		op({3'b100, 11'h555}, 1'b1, 8'h10);
		$display("test calls done");
	endtask : test_calls

	task test_others;
		for (int t = 0; t < 8; t++) begin
			if (t != 4) op({t[2:0], 11'h7ff}, 1'b1, 8'hff);
		end
		op({3'b100, 11'h123}, 1'b0, 8'h18);
		op({3'b100, 11'h321}, 1'b1, 8'h08);
		$display("test other words done");
	endtask : test_others

	task test_done;
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done

	initial begin
		sys_rst = 1'b1;
		clk_en = 1'b1;
		insn = 14'h0000;
		insn_valid = 1'b0;
		pc_high_latch = 8'h00;
		exp_pc = 13'h0000;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		test_calls();
		test_others();
		test_done();
	end
endmodule : scx_call_unit_bench
`default_nettype wire
